// File: serial_telegram_to_parallel_code.sv
// Function
// RL1: Antenna sends transparent telegram, length 7, content mask 100B.
// RL2: Receiver samples the serial link at 19200 baud.
// RL3: Eight-byte telegram: start '=', dummy, code low 16 bits, status, check.
// RL4: Extracted code drives parallel outputs and holds until next code.
// RL5: Strobe rises 10 ms after new code applied, stays high 100 ms.
// RL6: Every transponder entry gives a fresh strobe, even for same code.
// RL7: In-range output high while a transponder is in range, else low.
// RL8: Resync on start character; bad or short telegrams are discarded.
`include "tg_defines.svh"

module serial_telegram_to_parallel_code
  import tg_pkg::*;
#(
  parameter int   DELAY_CYC = `TG_STROBE_DELAY_MS * `TG_CLK_KHZ,
  parameter int   WIDTH_CYC = `TG_STROBE_WIDTH_MS * `TG_CLK_KHZ,
  parameter int   BIT_CYC   = `TG_BAUD_DIV,
  parameter int   TMR_W     = 23,
  parameter bit   LOW_FIRST = 1'b0
)
(
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  input  wire logic        RXD,
  output logic [15:0]      CODE,
  output logic             CODE_STROBE,
  output logic             IN_RANGE
);

  localparam logic [11:0] BAUD_DIV  = 12'(BIT_CYC);
  localparam logic [11:0] BAUD_HALF = 12'(BIT_CYC / 2);
  localparam logic [3:0]  LAST_BIT  = 4'(`TG_FRAME_BITS - 1);
  localparam logic [TMR_W-1:0] DELAY_END = TMR_W'(DELAY_CYC - 1);
  localparam logic [TMR_W-1:0] WIDTH_END = TMR_W'(WIDTH_CYC - 1);
  localparam logic [1:0]  DEPTH     = 2'(`TG_BUF_DEPTH);

  // ========================================================================
  // Serial receiver
  logic          rx_meta_r;
  logic          rx_sync_r;
  rx_state_e     rx_state_r;
  logic [11:0]   baud_cnt_r;
  logic [3:0]    bit_cnt_r;
  logic [8:0]    shift_r;
  logic          bit_end;
  logic          byte_ok;
  logic          byte_err;
  byte_t         rx_byte;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rx_meta_r <= 1'b1;
      rx_sync_r <= 1'b1;
    end
    else
    begin
      rx_meta_r <= RXD;
      rx_sync_r <= rx_meta_r;
    end
  end

  assign bit_end  = (baud_cnt_r == BAUD_DIV - 12'h001);
  assign rx_byte  = shift_r[7:0];
  assign byte_ok  = (rx_state_r == RX_STOP) && bit_end && rx_sync_r
                    && !(^shift_r);
  assign byte_err = (rx_state_r == RX_STOP) && bit_end && !byte_ok;

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rx_state_r <= RX_IDLE;
      baud_cnt_r <= 12'h000;
      bit_cnt_r  <= 4'h0;
      shift_r    <= 9'h000;
    end
    else
    begin
      unique case (rx_state_r)
        RX_IDLE:
        begin
          baud_cnt_r <= 12'h000;
          if (!rx_sync_r)
            rx_state_r <= RX_START;
        end
        RX_START:
        begin
          if (baud_cnt_r == BAUD_HALF - 12'h001)
          begin
            baud_cnt_r <= 12'h000;
            bit_cnt_r  <= 4'h0;
            rx_state_r <= rx_sync_r ? RX_IDLE : RX_DATA;
          end
          else
            baud_cnt_r <= baud_cnt_r + 12'h001;
        end
        RX_DATA:
        begin
          if (bit_end) // RL2
          begin
            baud_cnt_r <= 12'h000;
            shift_r    <= {rx_sync_r, shift_r[8:1]};
            bit_cnt_r  <= bit_cnt_r + 4'h1;
            if (bit_cnt_r == LAST_BIT)
              rx_state_r <= RX_STOP;
          end
          else
            baud_cnt_r <= baud_cnt_r + 12'h001;
        end
        RX_STOP:
        begin
          if (bit_end)
          begin
            baud_cnt_r <= 12'h000;
            rx_state_r <= RX_IDLE;
          end
          else
            baud_cnt_r <= baud_cnt_r + 12'h001;
        end
      endcase
    end
  end

  // ========================================================================
  // Telegram framer
  frame_state_e  fr_state_r;
  logic [2:0]    idx_r;
  byte_t         chk_r;
  telegram_s     tg_r;
  logic          push;
  logic          buf_in_ready;

  assign push = (fr_state_r == FR_BODY) && byte_ok
                && (idx_r == `TG_IDX_CHECK) && (rx_byte == chk_r); // RL8

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      fr_state_r <= FR_HUNT;
      idx_r      <= 3'h0;
      chk_r      <= 8'h00;
      tg_r       <= '0;
    end
    else if (byte_err)
      fr_state_r <= FR_HUNT; // RL8
    else if (byte_ok)
    begin
      unique case (fr_state_r)
        FR_HUNT:
        begin
          if (rx_byte == `TG_START_CHAR) // RL3 RL8
          begin
            fr_state_r <= FR_BODY;
            idx_r      <= `TG_IDX_FIRST;
            chk_r      <= rx_byte;
          end
        end
        FR_BODY:
        begin
          chk_r <= chk_r ^ rx_byte;
          idx_r <= idx_r + 3'h1;
          unique case (idx_r) // RL3
            `TG_IDX_CODE_A:
              if (LOW_FIRST) tg_r.code[7:0] <= rx_byte;
              else           tg_r.code[15:8] <= rx_byte;
            `TG_IDX_CODE_B:
              if (LOW_FIRST) tg_r.code[15:8] <= rx_byte;
              else           tg_r.code[7:0] <= rx_byte;
            `TG_IDX_STAT_A:
              if (LOW_FIRST) tg_r.status[7:0] <= rx_byte;
              else           tg_r.status[15:8] <= rx_byte;
            `TG_IDX_STAT_B:
              if (LOW_FIRST) tg_r.status[15:8] <= rx_byte;
              else           tg_r.status[7:0] <= rx_byte;
            `TG_IDX_CHECK:
              fr_state_r <= FR_HUNT;
            default:
              chk_r <= chk_r ^ rx_byte;
          endcase
        end
      endcase
    end
  end

  // ========================================================================
  // Two-entry telegram buffer
  telegram_s     buf_mem_r [2];
  logic          wr_ptr_r;
  logic          rd_ptr_r;
  logic [1:0]    count_r;
  logic          push_ok;
  logic          pop;
  logic          buf_out_valid;
  logic          buf_out_ready;
  telegram_s     buf_out;
  strobe_state_e st_state_r;

  assign buf_in_ready  = (count_r != DEPTH);
  assign push_ok       = push && buf_in_ready;
  assign buf_out_valid = (count_r != 2'h0);
  assign buf_out_ready = (st_state_r != ST_WAIT);
  assign pop           = buf_out_valid && buf_out_ready;
  assign buf_out       = buf_mem_r[rd_ptr_r];

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      buf_mem_r[0] <= '0;
      buf_mem_r[1] <= '0;
      wr_ptr_r     <= 1'b0;
      rd_ptr_r     <= 1'b0;
      count_r      <= 2'h0;
    end
    else
    begin
      if (push_ok)
      begin
        buf_mem_r[wr_ptr_r] <= tg_r;
        wr_ptr_r            <= !wr_ptr_r;
      end
      if (pop)
        rd_ptr_r <= !rd_ptr_r;
      if (push_ok && !pop)
        count_r <= count_r + 2'h1;
      else if (pop && !push_ok)
        count_r <= count_r - 2'h1;
    end
  end

  // ========================================================================
  // Parallel output and strobe timing
  logic [15:0]      code_r;
  logic             in_range_r;
  logic [TMR_W-1:0] tmr_r;
  logic             fresh;

  assign fresh = pop && (buf_out.code != 16'h0000)
                 && (!in_range_r || buf_out.code != code_r); // RL6

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      code_r     <= 16'h0000;
      in_range_r <= 1'b0;
    end
    else if (pop)
    begin
      code_r     <= buf_out.code; // RL4
      in_range_r <= (buf_out.code != 16'h0000); // RL7
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      st_state_r <= ST_IDLE;
      tmr_r      <= '0;
    end
    else if (fresh)
    begin
      st_state_r <= ST_WAIT; // RL6
      tmr_r      <= '0;
    end
    else
    begin
      unique case (st_state_r)
        ST_IDLE:
          tmr_r <= '0;
        ST_WAIT:
          if (tmr_r == DELAY_END) // RL5
          begin
            st_state_r <= ST_PULSE;
            tmr_r      <= '0;
          end
          else
            tmr_r <= tmr_r + TMR_W'(1);
        ST_PULSE:
          if (tmr_r == WIDTH_END) // RL5
            st_state_r <= ST_IDLE;
          else
            tmr_r <= tmr_r + TMR_W'(1);
        default:
          st_state_r <= ST_IDLE;
      endcase
    end
  end

  assign CODE        = code_r;
  assign IN_RANGE    = in_range_r;
  assign CODE_STROBE = (st_state_r == ST_PULSE);

  // ========================================================================
  // Checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_pulse_last;
    CODE_STROBE && tmr_r == WIDTH_END && !fresh;
  endsequence

  chk_code_hold: assert property (!pop |=> $stable(CODE)) // RL4
    else $error("Code changed without a new telegram");
  chk_strobe_delay: assert property ( // RL5
    st_state_r == ST_WAIT && tmr_r == DELAY_END && !fresh
    |=> CODE_STROBE && tmr_r == '0)
    else $error("Strobe did not rise at end of delay");
  chk_strobe_low: assert property (st_state_r == ST_WAIT |-> !CODE_STROBE)
    else $error("Strobe high during delay"); // RL5
  chk_strobe_width: assert property (s_pulse_last |=> !CODE_STROBE) // RL5
    else $error("Strobe did not fall at end of width");
  chk_fresh_entry: assert property ( // RL6
    fresh |=> st_state_r == ST_WAIT && tmr_r == '0 && CODE != 16'h0000)
    else $error("Entry did not restart strobe sequence");
  chk_in_range: assert property (IN_RANGE == (CODE != 16'h0000)) // RL7
    else $error("In-range level disagrees with code");
  chk_resync_start: assert property ( // RL3
    byte_ok && !byte_err && fr_state_r == FR_HUNT
    && rx_byte == `TG_START_CHAR
    |=> fr_state_r == FR_BODY && idx_r == `TG_IDX_FIRST)
    else $error("Start character did not open a telegram");
  chk_bad_check: assert property ( // RL8
    byte_ok && fr_state_r == FR_BODY && idx_r == `TG_IDX_CHECK
    && rx_byte != chk_r |-> !push
    ##1 fr_state_r == FR_HUNT)
    else $error("Bad telegram was accepted");
  chk_baud_tick: assert property ( // RL2
    rx_state_r == RX_DATA && bit_end |=> baud_cnt_r == 12'h000
    && (rx_state_r == RX_DATA || rx_state_r == RX_STOP))
    else $error("Bit period wrong");

endmodule // serial_telegram_to_parallel_code

// File: tg_defines.svh
`ifndef TG_DEFINES_SVH
`define TG_DEFINES_SVH

// ==========================================================================
// Clock and serial link timing
`define TG_CLK_KHZ          50000
`define TG_BAUD             19200
`define TG_BAUD_DIV         ((`TG_CLK_KHZ * 1000) / `TG_BAUD)
`define TG_BAUD_HALF        (`TG_BAUD_DIV / 2)
`define TG_FRAME_BITS       9

// ==========================================================================
// Telegram layout (byte index from 0)
`define TG_START_CHAR       8'h3D
`define TG_IDX_CODE_A       3'h3
`define TG_IDX_CODE_B       3'h4
`define TG_IDX_STAT_A       3'h5
`define TG_IDX_STAT_B       3'h6
`define TG_IDX_CHECK        3'h7
`define TG_IDX_FIRST        3'h1

// ==========================================================================
// Output timing and telegram buffer depth
`define TG_STROBE_DELAY_MS  10
`define TG_STROBE_WIDTH_MS  100
`define TG_BUF_DEPTH        2

`endif

// File: tg_pkg.sv
package tg_pkg;

  // ========================================================================
  // Types
  typedef logic [7:0] byte_t;

  typedef struct packed {
    logic [15:0] code;
    logic [15:0] status;
  } telegram_s;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'h0,
    RX_START = 2'h1,
    RX_DATA  = 2'h3,
    RX_STOP  = 2'h2
  } rx_state_e;

  typedef enum logic {
    FR_HUNT = 1'h0,
    FR_BODY = 1'h1
  } frame_state_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_WAIT  = 2'h1,
    ST_PULSE = 2'h3
  } strobe_state_e;

endpackage

// File: antenna_model.sv
`include "tg_defines.svh"

module antenna_model
  import tg_pkg::*;
#(
  parameter int BIT_CYC = `TG_BAUD_DIV
)
(
  input  wire logic CLK,
  output logic      RXD
);
  // ======================================================================
  // Serial telegram source, idle high
  initial RXD = 1'b1;

  task automatic send_byte(input byte_t b);
    logic [10:0] f;
    f = {1'b1, ^b, b, 1'b0};
    @(posedge CLK);
    #1;
    for (int i = 0; i < 11; i++)
    begin
      RXD = f[i];
      repeat (BIT_CYC) @(posedge CLK);
      #1;
    end
  endtask

  task automatic send_tg(input logic [15:0] code,
                         input logic [15:0] dummy,
                         input logic [15:0] status,
                         input bit          bad);
    byte_t t[8];
    byte_t x;
    t = '{8'h3D, dummy[15:8], dummy[7:0], code[15:8], code[7:0],
          status[15:8], status[7:0], 8'h00};
    x = 8'h00;
    for (int i = 0; i < 7; i++)
      x ^= t[i];
    t[7] = bad ? ~x : x;
    foreach (t[i])
      send_byte(t[i]);
  endtask
endmodule // antenna_model

// File: tb_serial_telegram_to_parallel_code.sv
module tb_serial_telegram_to_parallel_code;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int DLY   = 20;
  localparam int WID   = 50;
  localparam int BIT   = 32;
  localparam int LIMIT = 40000;

  logic        clk;
  logic        reset_n;
  wire logic   rxd;
  logic [15:0] code;
  logic        code_strobe;
  logic        in_range;
  logic [31:0] rs;
  logic [15:0] held;
  logic [15:0] a;
  int          mismatches;
  int          checks;
  int          cyc;

  // ======================================================================
  // Design and far side
  serial_telegram_to_parallel_code #(
    .DELAY_CYC (DLY),
    .WIDTH_CYC (WID),
    .BIT_CYC   (BIT)
  ) dut (
    .CLK         (clk),
    .RESET_N     (reset_n),
    .RXD         (rxd),
    .CODE        (code),
    .CODE_STROBE (code_strobe),
    .IN_RANGE    (in_range)
  );

  antenna_model #(
    .BIT_CYC (BIT)
  ) ant (
    .CLK (clk),
    .RXD (rxd)
  );

  // ======================================================================
  // Clock and timeout
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      mismatches++;
      close_out();
    end
  end

  // ======================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [15:0] nxt16();
    rs = lfsr(rs);
    return rs[15:0];
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One telegram, then code, range and strobe timing
  task automatic run_tg(input logic [15:0] c, input logic [15:0] dm,
                        input bit bad, input bit fresh);
    logic [15:0] want;
    logic [15:0] st;
    int          n;
    want = bad ? held : c;
    st = nxt16();
    fork
      ant.send_tg(c, dm, st, bad);
    join_none
    if (bad)
      wait fork;
    n = 0;
    while (code !== want && n < 4000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("code", {16'h0000, want}, {16'h0000, code});
    chk("in_range", {31'h0, want != 16'h0}, {31'h0, in_range});
    n = 0;
    if (fresh)
    begin
      while (code_strobe !== 1'b1 && n < 200)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      chk("strobe_delay", DLY, n);
      n = 0;
      while (code_strobe === 1'b1 && n < 200)
      begin
        @(posedge clk);
        #1;
        n++;
      end
      chk("strobe_width", WID, n);
      chk("code_held", {16'h0000, want}, {16'h0000, code});
    end
    else
    begin
      repeat (DLY + WID + 10)
      begin
        @(posedge clk);
        #1;
        if (code_strobe !== 1'b0)
          n++;
      end
      chk("no_strobe", 0, n);
    end
    wait fork;
    if (!bad)
      held = c;
  endtask

  // ======================================================================
  // Main sequence
  initial
  begin
    mismatches = 0;
    checks = 0;
    cyc = 0;
    rs = 32'hDAA83BDE;
    held = 16'h0000;
    reset_n = 1'b0;
    repeat (16) @(posedge clk);
    #1;
    chk("reset_code", 0, {16'h0000, code});
    chk("reset_range", 0, {31'h0, in_range});
    reset_n = 1'b1;
    repeat (4) @(posedge clk);
    a = nxt16() | 16'h0001;
    run_tg(a, nxt16(), 1'b0, 1'b1);
    run_tg(~a, 16'h3D3D, 1'b1, 1'b0);
    run_tg(16'h0000, nxt16(), 1'b0, 1'b0);
    run_tg(a, nxt16(), 1'b0, 1'b1);
    run_tg(a ^ 16'h8000, nxt16(), 1'b0, 1'b1);
    close_out();
  end
endmodule // tb_serial_telegram_to_parallel_code
